// ---- pkg/perf_event_pkg.sv ----
// Event codes, unit masks, register map and field layout for the event decoder
package perf_event_pkg;
  localparam int DATA_W = 32;
  localparam int CODE_W = 8;
  localparam int MASK_W = 8;
  // Register byte offsets
  localparam logic [11:0] OFF_SELECT_0 = 12'h000;
  localparam logic [11:0] OFF_SELECT_1 = 12'h004;
  localparam logic [11:0] OFF_COUNT_0 = 12'h008;
  localparam logic [11:0] OFF_COUNT_1 = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  // Select register fields
  localparam int SEL_CODE_LSB = 0;
  localparam int SEL_MASK_LSB = 8;
  localparam int SEL_EN_BIT = 22;
  localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] SELECT_WMASK = 32'h0040_FFFF;
  // Event codes
  localparam logic [7:0] EV_RESOURCE_STALL = 8'hA2;
  localparam logic [7:0] EV_PARTIAL_STALL = 8'hD2;
  localparam logic [7:0] EV_SEG_LOAD = 8'h06;
  localparam logic [7:0] EV_UNHALTED = 8'h79;
  localparam logic [7:0] EV_PACKED_EXEC = 8'hB0;
  localparam logic [7:0] EV_PACKED_SAT = 8'hB1;
  localparam logic [7:0] EV_PACKED_UOPS = 8'hB2;
  localparam logic [7:0] EV_PACKED_CLASS = 8'hB3;
  localparam logic [7:0] EV_SIMD_SWITCH = 8'hCC;
  localparam logic [7:0] EV_EMPTY_STATE = 8'hCD;
  localparam logic [7:0] EV_PACKED_RET = 8'hCE;
  localparam logic [7:0] EV_SEG_REN_STALL = 8'hD4;
  localparam logic [7:0] EV_SEG_RENAME = 8'hD5;
  localparam logic [7:0] EV_SEG_REN_RET = 8'hD6;
  // Unit masks
  localparam logic [7:0] UM_NONE = 8'h00;
  localparam logic [7:0] UM_ONE = 8'h01;
  localparam logic [7:0] UM_ALL_LOW = 8'h0F;
  localparam logic [7:0] UM_CLASS_ALL = 8'h3F;
  localparam int NUM_CLASS = 6;
  localparam int NUM_SEG = 4;
  // Width of a per-cycle event count
  localparam int INC_W = 3;
endpackage : perf_event_pkg

// ---- src/perf_event_route.sv ----
// Decodes one event select into a per-cycle increment from the core strobes
`timescale 1ns/100ps
module perf_event_route (
  input wire logic [7:0] code_i,
  input wire logic [7:0] unit_qualifier_field_i,
  input wire logic resource_stall_i,
  input wire logic stall_bus_queue_full_i,
  input wire logic stall_miss_limit_i,
  input wire logic branch_recovery_stall_i,
  input wire logic store_drain_stall_i,
  input wire logic partial_alias_stall_i,
  input wire logic seg_load_i,
  input wire logic halted_i,
  input wire logic packed_exec_i,
  input wire logic packed_move_store_i,
  input wire logic packed_sat_i,
  input wire logic [2:0] packed_uops_i,
  input wire logic [5:0] packed_class_i,
  input wire logic packed_to_float_i,
  input wire logic float_to_packed_i,
  input wire logic empty_packed_state_insn_i,
  input wire logic packed_retired_i,
  input wire logic [3:0] seg_rename_stall_i,
  input wire logic [3:0] seg_rename_i,
  input wire logic seg_rename_retired_i,
  output logic [2:0] inc_o
);
  function automatic logic [2:0] bit_count(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < 6; k++) begin
      n = n + {2'h0, v[k]};
    end
    return n;
  endfunction : bit_count

  logic [7:0] um;
  logic [5:0] cls;
  logic [3:0] seg;
  assign um = unit_qualifier_field_i;
  assign cls = um[5:0];
  assign seg = um[3:0];

  always_comb begin
    inc_o = 3'h0;
    case (code_i)
      // RQ1: Resource stall cycles
      perf_event_pkg::EV_RESOURCE_STALL: begin
        if (um == perf_event_pkg::UM_NONE) begin
          // RQ3: Exclude queue/miss stalls
          // RQ4: Add recovery, drain stalls
          inc_o = {2'h0, ((resource_stall_i && !stall_bus_queue_full_i && !stall_miss_limit_i)
                   || branch_recovery_stall_i || store_drain_stall_i)};
        end
      end
      // RQ5: Partial stalls, flags included
      perf_event_pkg::EV_PARTIAL_STALL:
        if (um == perf_event_pkg::UM_NONE) inc_o = {2'h0, partial_alias_stall_i};
      // RQ6: One per segment load
      perf_event_pkg::EV_SEG_LOAD:
        if (um == perf_event_pkg::UM_NONE) inc_o = {2'h0, seg_load_i};
      // RQ7: Count unhalted cycles
      perf_event_pkg::EV_UNHALTED:
        if (um == perf_event_pkg::UM_NONE) inc_o = {2'h0, !halted_i};
      // RQ8: Executed, minus move stores
      perf_event_pkg::EV_PACKED_EXEC:
        if (um == perf_event_pkg::UM_NONE) inc_o = {2'h0, packed_exec_i && !packed_move_store_i};
      // RQ9: Saturating executed
      perf_event_pkg::EV_PACKED_SAT:
        if (um == perf_event_pkg::UM_NONE) inc_o = {2'h0, packed_sat_i};
      // RQ10: Micro-ops with mask 0FH
      perf_event_pkg::EV_PACKED_UOPS:
        if (um == perf_event_pkg::UM_ALL_LOW) inc_o = packed_uops_i;
      // RQ11: Class chosen by mask bits
      perf_event_pkg::EV_PACKED_CLASS:
        if (um[7:6] == 2'h0) inc_o = bit_count(packed_class_i & cls);
      // RQ12: Direction chosen by mask
      perf_event_pkg::EV_SIMD_SWITCH: begin
        if (um == perf_event_pkg::UM_NONE) inc_o = {2'h0, packed_to_float_i};
        else if (um == perf_event_pkg::UM_ONE) inc_o = {2'h0, float_to_packed_i};
      end
      // RQ13: State-empty instructions
      perf_event_pkg::EV_EMPTY_STATE:
        if (um == perf_event_pkg::UM_NONE) inc_o = {2'h0, empty_packed_state_insn_i};
      // RQ14: Retired packed instructions
      perf_event_pkg::EV_PACKED_RET:
        if (um == perf_event_pkg::UM_NONE) inc_o = {2'h0, packed_retired_i};
      // RQ15: Rename stalls per register
      perf_event_pkg::EV_SEG_REN_STALL:
        if (um[7:4] == 4'h0) inc_o = bit_count({2'h0, seg_rename_stall_i & seg});
      // RQ16: Renames per register
      perf_event_pkg::EV_SEG_RENAME:
        if (um[7:4] == 4'h0) inc_o = bit_count({2'h0, seg_rename_i & seg});
      // RQ17: Retired renames, zero mask
      perf_event_pkg::EV_SEG_REN_RET:
        if (um == perf_event_pkg::UM_NONE) inc_o = {2'h0, seg_rename_retired_i};
      // RQ18: Unknown codes add nothing
      default: inc_o = 3'h0;
    endcase
  end
endmodule : perf_event_route

// ---- src/perf_event_select_decoder.sv ----
// Two event counters with select registers behind an AHB-Lite slave
`timescale 1ns/100ps

// Notes on behaviour
// RQ1: Resource-stall code counts each stalled cycle
// RQ2: Software writes unit mask beside code
// RQ3: Bus-queue and miss-limit stalls excluded
// RQ4: Branch recovery and store drain included
// RQ5: Partial-stall code, zero mask, counts stalls
// RQ6: Segment-load code counts every load
// RQ7: Unhalted code counts non-halted cycles
// RQ8: Packed executed, excluding move stores
// RQ9: Saturating packed instructions executed
// RQ10: Packed micro-ops counted with mask 0FH
// RQ11: Mask bits pick instruction class
// RQ12: Mask 00H/01H picks switch direction
// RQ13: Counts state-empty instruction executions
// RQ14: Counts retired packed instructions
// RQ15: Rename stalls, per-register mask bits
// RQ16: Renames, per-register mask bits
// RQ17: Retired renames with zero mask
// RQ18: Undecoded combinations never increment
// RQ19: Strobe sampled and added same cycle
module perf_event_select_decoder #(
  parameter int COUNT_W = 32
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic resource_stall_i,
  input wire logic stall_bus_queue_full_i,
  input wire logic stall_miss_limit_i,
  input wire logic branch_recovery_stall_i,
  input wire logic store_drain_stall_i,
  input wire logic partial_alias_stall_i,
  input wire logic seg_load_i,
  input wire logic halted_i,
  input wire logic packed_exec_i,
  input wire logic packed_move_store_i,
  input wire logic packed_sat_i,
  input wire logic [2:0] packed_uops_i,
  input wire logic [5:0] packed_class_i,
  input wire logic packed_to_float_i,
  input wire logic float_to_packed_i,
  input wire logic empty_packed_state_insn_i,
  input wire logic packed_retired_i,
  input wire logic [3:0] seg_rename_stall_i,
  input wire logic [3:0] seg_rename_i,
  input wire logic seg_rename_retired_i,
  output logic [1:0] count_active_o
);
  if (COUNT_W < 8 || COUNT_W > 32) begin : g_bad_width
    $error("COUNT_W must lie between 8 and 32");
  end

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_WRITE = 1'b1
  } phase_e;

  typedef struct packed {
    phase_e phase;
    logic [11:0] waddr;
    logic [31:0] sel0;
    logic [31:0] sel1;
    logic [COUNT_W-1:0] cnt0;
    logic [COUNT_W-1:0] cnt1;
    logic [31:0] rdata;
    logic [1:0] active;
    logic ready;
    logic resp;
  } state_s;

  state_s state_r;
  state_s state_nxt;
  logic [2:0] inc0;
  logic [2:0] inc1;
  logic addr_take;

  // Read value of one mapped offset, zero elsewhere
  function automatic logic [31:0] read_word(input state_s s, input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      perf_event_pkg::OFF_SELECT_0: v = s.sel0;
      perf_event_pkg::OFF_SELECT_1: v = s.sel1;
      perf_event_pkg::OFF_COUNT_0: v = 32'(s.cnt0);
      perf_event_pkg::OFF_COUNT_1: v = 32'(s.cnt1);
      perf_event_pkg::OFF_STATUS: v = {30'h0, s.active};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_word

  // Counter step, with the enable bit gating it
  function automatic logic [COUNT_W-1:0] step(input logic [COUNT_W-1:0] c, input logic en,
                                              input logic [2:0] inc);
    logic [COUNT_W-1:0] r;
    r = c;
    if (en) begin
      r = c + COUNT_W'(inc);
    end
    return r;
  endfunction : step

  // RQ2: Code and mask from select word
  perf_event_route u_route0 (
    .code_i(state_r.sel0[perf_event_pkg::SEL_CODE_LSB +: 8]),
    .unit_qualifier_field_i(state_r.sel0[perf_event_pkg::SEL_MASK_LSB +: 8]),
    .resource_stall_i(resource_stall_i),
    .stall_bus_queue_full_i(stall_bus_queue_full_i),
    .stall_miss_limit_i(stall_miss_limit_i),
    .branch_recovery_stall_i(branch_recovery_stall_i),
    .store_drain_stall_i(store_drain_stall_i),
    .partial_alias_stall_i(partial_alias_stall_i),
    .seg_load_i(seg_load_i),
    .halted_i(halted_i),
    .packed_exec_i(packed_exec_i),
    .packed_move_store_i(packed_move_store_i),
    .packed_sat_i(packed_sat_i),
    .packed_uops_i(packed_uops_i),
    .packed_class_i(packed_class_i),
    .packed_to_float_i(packed_to_float_i),
    .float_to_packed_i(float_to_packed_i),
    .empty_packed_state_insn_i(empty_packed_state_insn_i),
    .packed_retired_i(packed_retired_i),
    .seg_rename_stall_i(seg_rename_stall_i),
    .seg_rename_i(seg_rename_i),
    .seg_rename_retired_i(seg_rename_retired_i),
    .inc_o(inc0)
  );

  perf_event_route u_route1 (
    .code_i(state_r.sel1[perf_event_pkg::SEL_CODE_LSB +: 8]),
    .unit_qualifier_field_i(state_r.sel1[perf_event_pkg::SEL_MASK_LSB +: 8]),
    .resource_stall_i(resource_stall_i),
    .stall_bus_queue_full_i(stall_bus_queue_full_i),
    .stall_miss_limit_i(stall_miss_limit_i),
    .branch_recovery_stall_i(branch_recovery_stall_i),
    .store_drain_stall_i(store_drain_stall_i),
    .partial_alias_stall_i(partial_alias_stall_i),
    .seg_load_i(seg_load_i),
    .halted_i(halted_i),
    .packed_exec_i(packed_exec_i),
    .packed_move_store_i(packed_move_store_i),
    .packed_sat_i(packed_sat_i),
    .packed_uops_i(packed_uops_i),
    .packed_class_i(packed_class_i),
    .packed_to_float_i(packed_to_float_i),
    .float_to_packed_i(float_to_packed_i),
    .empty_packed_state_insn_i(empty_packed_state_insn_i),
    .packed_retired_i(packed_retired_i),
    .seg_rename_stall_i(seg_rename_stall_i),
    .seg_rename_i(seg_rename_i),
    .seg_rename_retired_i(seg_rename_retired_i),
    .inc_o(inc1)
  );

  assign addr_take = hsel_i && hready_i && htrans_i[1];

  always_comb begin
    state_nxt = state_r;
    // RQ19: Add this cycle's events
    // RQ18: Zero increment for unknown codes
    state_nxt.cnt0 = step(state_r.cnt0, state_r.sel0[perf_event_pkg::SEL_EN_BIT], inc0);
    state_nxt.cnt1 = step(state_r.cnt1, state_r.sel1[perf_event_pkg::SEL_EN_BIT], inc1);
    state_nxt.active = {state_r.sel1[perf_event_pkg::SEL_EN_BIT], state_r.sel0[perf_event_pkg::SEL_EN_BIT]};
    // Write data phase; a bus write wins over the counting step
    if (state_r.phase == PH_WRITE) begin
      case (state_r.waddr)
        perf_event_pkg::OFF_SELECT_0: state_nxt.sel0 = hwdata_i & perf_event_pkg::SELECT_WMASK;
        perf_event_pkg::OFF_SELECT_1: state_nxt.sel1 = hwdata_i & perf_event_pkg::SELECT_WMASK;
        perf_event_pkg::OFF_COUNT_0: state_nxt.cnt0 = hwdata_i[COUNT_W-1:0];
        perf_event_pkg::OFF_COUNT_1: state_nxt.cnt1 = hwdata_i[COUNT_W-1:0];
        default: state_nxt.phase = PH_IDLE;
      endcase
    end
    state_nxt.phase = PH_IDLE;
    if (addr_take) begin
      // Read data is sampled at the address phase edge, zero wait states
      state_nxt.rdata = hwrite_i ? 32'h0000_0000 : read_word(state_r, haddr_i[11:0]);
      if (hwrite_i) begin
        state_nxt.phase = PH_WRITE;
        state_nxt.waddr = haddr_i[11:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r.phase <= PH_IDLE;
      state_r.waddr <= 12'h000;
      state_r.sel0 <= perf_event_pkg::SELECT_RESET;
      state_r.sel1 <= perf_event_pkg::SELECT_RESET;
      state_r.cnt0 <= COUNT_W'(perf_event_pkg::COUNT_RESET);
      state_r.cnt1 <= COUNT_W'(perf_event_pkg::COUNT_RESET);
      state_r.rdata <= 32'h0000_0000;
      state_r.active <= 2'h0;
      state_r.ready <= 1'b1;
      state_r.resp <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Zero wait states, always OKAY; held in flops so no output is combinational
  assign hreadyout_o = state_r.ready;
  assign hresp_o = state_r.resp;
  assign hrdata_o = state_r.rdata;
  assign count_active_o = state_r.active;
endmodule : perf_event_select_decoder

// ---- verification/core_strobe_model.sv ----
// Core pipeline model driving the per-cycle event strobes
`timescale 1ns/100ps
module core_strobe_model (
  input wire logic clk_i,
  input wire logic play_i,
  input wire logic [32:0] vec_i,
  output logic [32:0] strobes_o
);
  // Halted between bursts, so idle cycles never look unhalted
  always_ff @(posedge clk_i) begin
    strobes_o <= play_i ? vec_i : 33'h0_0000_0080;
  end
endmodule : core_strobe_model

// ---- verification/perf_event_select_decoder_asserts.sv ----
// Port-level checks for the event counter block
`timescale 1ns/100ps
module perf_event_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [1:0] count_active_o
);
  logic take;
  logic hi;
  logic [4:0] ph_r;
  assign take = hsel_i & hready_i & htrans_i[1];
  assign hi = haddr_i[31:12] == 20'h0;
  // Data-phase flags: sel0 write, sel1 write, select read, unmapped read, status read
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ph_r <= 5'h0;
    end else begin
      ph_r <= {5{take & hi}} & {!hwrite_i && haddr_i[11:0] == perf_event_pkg::OFF_STATUS,
        !hwrite_i && haddr_i[11:0] > perf_event_pkg::OFF_STATUS,
        !hwrite_i && haddr_i[11:0] <= perf_event_pkg::OFF_SELECT_1,
        hwrite_i && haddr_i[11:0] == perf_event_pkg::OFF_SELECT_1,
        hwrite_i && haddr_i[11:0] == perf_event_pkg::OFF_SELECT_0};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_en0_write;
    ph_r[0] && hwdata_i[22];
  endsequence
  sequence s_dis0_write;
    ph_r[0] && !hwdata_i[22];
  endsequence
  property p_ready; hreadyout_o; endproperty
  property p_okay; !hresp_o; endproperty
  property p_hold; !$past(take) |-> $stable(hrdata_o); endproperty
  property p_en0_on; s_en0_write |-> ##[1:2] count_active_o[0]; endproperty
  property p_en0_off; s_dis0_write |-> ##[1:2] !count_active_o[0]; endproperty
  property p_en1_on; ph_r[1] && hwdata_i[22] |-> ##[1:2] count_active_o[1]; endproperty
  property p_sel_rsv; ph_r[2] |-> (hrdata_o & ~perf_event_pkg::SELECT_WMASK) == 32'h0; endproperty
  property p_unmap; ph_r[3] |-> hrdata_o == 32'h0; endproperty
  property p_stat; ph_r[4] |-> hrdata_o[31:2] == 30'h0; endproperty
  property p_rst; $fell(reset_i) |-> count_active_o == 2'h0 && hrdata_o == 32'h0; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("error response");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_en0_on: assert property (p_en0_on) else $error("counter 0 not enabled");
  a_en0_off: assert property (p_en0_off) else $error("counter 0 not disabled");
  a_en1_on: assert property (p_en1_on) else $error("counter 1 not enabled");
  a_sel_rsv: assert property (p_sel_rsv) else $error("select spare bits set");
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  a_stat: assert property (p_stat) else $error("status spare bits set");
  a_rst: assert property (p_rst) else $error("state after reset");
endmodule : perf_event_checker
bind perf_event_select_decoder perf_event_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .count_active_o(count_active_o));

// ---- verification/testbench.sv ----
// Self-checking bench for the event select decoder
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, play = 1'b0, rd_ph = 1'b0, hready, hresp;
  logic [1:0] htrans = 2'h0, active;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [32:0] vec = 33'h0, st;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int checks = 0;
  // Code and unit mask pairs; last seven are undecoded
  logic [15:0] sel_tab[] = '{16'hA200, 16'hD200, 16'h0600, 16'h7900, 16'hB000, 16'hB100, 16'hB20F,
    16'hB301, 16'hB302, 16'hB304, 16'hB308, 16'hB310, 16'hB320, 16'hB33F, 16'hCC00, 16'hCC01, 16'hCD00,
    16'hCE00, 16'hD401, 16'hD402, 16'hD404, 16'hD408, 16'hD40F, 16'hD501, 16'hD502, 16'hD504, 16'hD508,
    16'hD50F, 16'hD600, 16'hB200, 16'hA201, 16'hD601, 16'hCC02, 16'hB340, 16'hD410, 16'h0000};
  always #20 clk_i = ~clk_i;
  core_strobe_model core (.clk_i(clk_i), .play_i(play), .vec_i(vec), .strobes_o(st));
  perf_event_select_decoder DUT (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .resource_stall_i(st[0]),
    .stall_bus_queue_full_i(st[1]), .stall_miss_limit_i(st[2]), .branch_recovery_stall_i(st[3]),
    .store_drain_stall_i(st[4]), .partial_alias_stall_i(st[5]), .seg_load_i(st[6]), .halted_i(st[7]),
    .packed_exec_i(st[8]), .packed_move_store_i(st[9]), .packed_sat_i(st[10]), .packed_uops_i(st[13:11]),
    .packed_class_i(st[19:14]), .packed_to_float_i(st[20]), .float_to_packed_i(st[21]),
    .empty_packed_state_insn_i(st[22]), .packed_retired_i(st[23]), .seg_rename_stall_i(st[27:24]),
    .seg_rename_i(st[31:28]), .seg_rename_retired_i(st[32]), .count_active_o(active));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task stop_test;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
  endtask : bus
  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  function automatic int inc_of(input logic [15:0] cm, input logic [32:0] v);
    logic [7:0] m;
    logic r;
    m = cm[7:0];
    r = 1'b0;
    case (cm[15:8])
      8'hA2: r = (v[0] & !v[1] & !v[2]) | v[3] | v[4];
      8'hD2: r = v[5];
      8'h06: r = v[6];
      8'h79: r = !v[7];
      8'hB0: r = v[8] & !v[9];
      8'hB1: r = v[10];
      8'hCD: r = v[22];
      8'hCE: r = v[23];
      8'hD6: r = v[32];
      8'hB2: return m == 8'h0F ? int'(v[13:11]) : 0;
      8'hB3: return m[7:6] == 2'h0 ? $countones(v[19:14] & m[5:0]) : 0;
      8'hCC: return m == 8'h00 ? int'(v[20]) : (m == 8'h01 ? int'(v[21]) : 0);
      8'hD4: return m[7:4] == 4'h0 ? $countones(v[27:24] & m[3:0]) : 0;
      8'hD5: return m[7:4] == 4'h0 ? $countones(v[31:28] & m[3:0]) : 0;
      default: return 0;
    endcase
    return (m == 8'h00 && r) ? 1 : 0;
  endfunction : inc_of
  // Read data is taken at the edge closing its data phase
  always @(posedge clk_i) begin
    if (rd_ph) check("hrdata", hrdata, exp_q.pop_front());
    rd_ph <= hsel & htrans[1] & !hwrite & hready;
  end
  initial begin
    repeat (8000) @(posedge clk_i);
    err_count++;
    stop_test();
  end
  initial begin
    logic [63:0] r;
    int e;
    int k;
    void'($urandom(9098));
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    for (k = 0; k < 6; k++) rd(12'(4 * k), 32'h0);
    bus(1'b1, 12'h014, 32'hFFFF_FFFF);
    rd(12'h014, 32'h0);
    bus(1'b1, perf_event_pkg::OFF_SELECT_1, 32'hFFFF_FFFF);
    rd(perf_event_pkg::OFF_SELECT_1, perf_event_pkg::SELECT_WMASK);
    rd(perf_event_pkg::OFF_STATUS, 32'h2);
    foreach (sel_tab[i]) begin
      k = i % 2;
      e = 0;
      bus(1'b1, perf_event_pkg::OFF_SELECT_0 + 12'(4 * k), {16'h0040, sel_tab[i][7:0], sel_tab[i][15:8]});
      bus(1'b1, perf_event_pkg::OFF_COUNT_0 + 12'(4 * k), 32'h0);
      repeat (8) begin
        r = {$urandom, $urandom};
        vec <= r[32:0];
        play <= 1'b1;
        e += inc_of(sel_tab[i], r[32:0]);
        @(posedge clk_i);
      end
      play <= 1'b0;
      repeat (3) @(posedge clk_i);
      bus(1'b1, perf_event_pkg::OFF_SELECT_0 + 12'(4 * k), {16'h0000, sel_tab[i][7:0], sel_tab[i][15:8]});
      rd(perf_event_pkg::OFF_COUNT_0 + 12'(4 * k), 32'(e));
    end
    repeat (3) @(posedge clk_i);
    stop_test();
  end
endmodule : testbench
